// [inc/strap_arb_pkg.sv]
// package for the strap-configured system bus master and arbitration logic
package strap_arb_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [7:0] STRAP_CFG_OFF = 8'h00;
	localparam logic [7:0] WAKE_ADDR_OFF = 8'h04;
	localparam logic [7:0] XFER_CTRL_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0C;
	localparam logic [7:0] PORT_NUM_OFF = 8'h10;
	localparam logic [7:0] PAGE_BASE_OFF = 8'h14;

	// ------------------------------------------------------------
	// strap configuration field positions
	// ------------------------------------------------------------
	localparam int PORT16_BIT = 0;
	localparam int DATA16_BIT = 1;
	localparam int CBRQ_BUS_BIT = 2;
	localparam int ANY_BIT = 3;
	localparam int SERIAL_BIT = 4;
	localparam int LOCK_EN_BIT = 5;
	localparam int HIGH_PAGE_BIT = 6;
	localparam int INT_SEL_LSB = 8;
	localparam int INT_SEL_W = 3;
	localparam int TERM_LSB = 12;
	localparam int OPT_LSB = 16;
	localparam int DREQ_LSB = 20;

	// transfer control bits
	localparam int XF_GO_BIT = 0;
	localparam int XF_MULTI_BIT = 1;
	localparam int XF_IRQ_BIT = 2;
	localparam int XF_COUNT_LSB = 8;
	localparam int XF_COUNT_W = 8;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int WAKE_W = 16;
	localparam int PAGE_W = 4;
	localparam logic [PAGE_W-1:0] PAGE_LOW = 4'h0;
	localparam logic [PAGE_W-1:0] PAGE_HIGH = 4'hF;
	localparam logic [31:0] STRAP_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0] PORT8_MASK = 8'hFF;

	// arbiter states
	typedef enum logic [2:0] {
		ARB_IDLE,
		ARB_REQ,
		ARB_OWN,
		ARB_XFER,
		ARB_PARK
	} arb_state_t;

	// bus-facing arbitration pins, true level except active-low busy_oe_n and cbrq_oe_n (inversion done at the pad)
	typedef struct packed {
		logic busy_out;
		logic busy_oe_n;
		logic breq;
		logic bpro;
		logic cbrq_out;
		logic cbrq_oe_n;
		logic lock;
	} arb_pins_t;

endpackage : strap_arb_pkg

// [rtl/strap_arb.sv]
// strap-configured system bus master arbitration, port decode and routing
`timescale 1ns/1ps

module strap_arb #(
	parameter int SOCKETS = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// straps, fitted reads high
	input wire logic [31:0] strap_cfg_i,
	input wire logic [strap_arb_pkg::WAKE_W-1:0] wake_strap_i,
	// internal interrupt request
	input wire logic irq_i,
	// bus arbitration inputs, true level
	input wire logic bprn_i,
	input wire logic busy_in_i,
	input wire logic cbrq_in_i,
	// bus arbitration outputs
	output strap_arb_pkg::arb_pins_t arb_o,
	output logic [7:0] int_o,
	output logic bus_16_o,
	output logic [strap_arb_pkg::PAGE_W-1:0] page_o,
	// expansion sockets
	input wire logic [SOCKETS-1:0] opt0_in_i,
	input wire logic [SOCKETS-1:0] opt1_in_i,
	input wire logic [SOCKETS-1:0] dreq_i,
	input wire logic [SOCKETS-1:0] opt0_val_i,
	input wire logic [SOCKETS-1:0] opt1_val_i,
	output logic [SOCKETS-1:0] term_en_o,
	output logic [SOCKETS-1:0] opt0_out_o,
	output logic [SOCKETS-1:0] opt0_oe_n_o,
	output logic [SOCKETS-1:0] opt1_out_o,
	output logic [SOCKETS-1:0] opt1_oe_n_o,
	output logic dma_req_o
);

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	logic [31:0] cfg_q;
	logic [strap_arb_pkg::WAKE_W-1:0] wake_q;
	logic cap_done_q;

	// straps are jumpers: one capture, no synchroniser, and bus pins arrive in this clock
	// a strap moved while running takes effect only after the next reset
	// caught once after release; later strap wiggles are ignored on purpose
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= strap_arb_pkg::STRAP_RESET;
			wake_q <= '0;
			cap_done_q <= 1'b0;
		end else if (!cap_done_q) begin
			cfg_q <= strap_cfg_i;
			wake_q <= wake_strap_i;
			cap_done_q <= 1'b1;
		end
	end

	// field views of the captured straps
	logic port16, data16, cbrq_bus, any_req, serial, lock_en, high_page;
	logic [strap_arb_pkg::INT_SEL_W-1:0] int_sel;
	assign port16 = cfg_q[strap_arb_pkg::PORT16_BIT];
	assign data16 = cfg_q[strap_arb_pkg::DATA16_BIT];
	assign cbrq_bus = cfg_q[strap_arb_pkg::CBRQ_BUS_BIT];
	assign any_req = cfg_q[strap_arb_pkg::ANY_BIT];
	assign serial = cfg_q[strap_arb_pkg::SERIAL_BIT];
	assign lock_en = cfg_q[strap_arb_pkg::LOCK_EN_BIT];
	assign high_page = cfg_q[strap_arb_pkg::HIGH_PAGE_BIT];
	assign int_sel = cfg_q[strap_arb_pkg::INT_SEL_LSB +: strap_arb_pkg::INT_SEL_W];

	// ------------------------------------------------------------
	// port decode, data width and page
	// ------------------------------------------------------------
	logic [strap_arb_pkg::WAKE_W-1:0] port_num_q;
	logic [strap_arb_pkg::PAGE_W-1:0] page_q;
	logic bus16_q;

	// refreshed every cycle from captured straps, valid two edges after reset
	// the mask is kept although the slice already drops the upper byte
	// upper byte masked off for hosts with 8-bit port addressing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_num_q <= '0;
		end else if (port16) begin
			port_num_q <= wake_q;
		end else begin
			port_num_q <= {8'h00, wake_q[7:0] & strap_arb_pkg::PORT8_MASK};
		end
	end

	// page is only the upper address nibble; the job supplies the lower bits
	// wide transfers depend only on the strap, not on the host's own width
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus16_q <= 1'b0;
			page_q <= strap_arb_pkg::PAGE_LOW;
		end else begin
			bus16_q <= data16;
			page_q <= high_page ? strap_arb_pkg::PAGE_HIGH : strap_arb_pkg::PAGE_LOW;
		end
	end

	// ------------------------------------------------------------
	// interrupt routing
	// ------------------------------------------------------------
	logic irq_sw_q;
	logic [7:0] int_q;

	// the software bit shares the line, so the path can be raised without the core
	// there is no enable: software must drop its own bit
	// at most one line is ever active; none while both requests are low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_q <= 8'h00;
		end else begin
			int_q <= (irq_i | irq_sw_q) ? (8'h01 << int_sel) : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// expansion socket routing
	// ------------------------------------------------------------
	logic [SOCKETS-1:0] term_q, o0_q, o0_oe_n_q, o1_q, o1_oe_n_q;
	logic [SOCKETS-1:0] o0_rx_q, o1_rx_q;
	logic dma_q;

	// one copy of the socket logic per socket; the status word assumes two
	genvar g;
	generate
		for (g = 0; g < SOCKETS; g++) begin : g_sock
			// a driven line reads back as zero so the board never hears its own echo
			// a fitted strap drives the option line, absent leaves it as input
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					term_q[g] <= 1'b0;
					o0_q[g] <= 1'b0;
					o1_q[g] <= 1'b0;
					o0_oe_n_q[g] <= 1'b1;
					o1_oe_n_q[g] <= 1'b1;
					o0_rx_q[g] <= 1'b0;
					o1_rx_q[g] <= 1'b0;
				end else begin
					term_q[g] <= cfg_q[strap_arb_pkg::TERM_LSB + g];
					o0_oe_n_q[g] <= ~cfg_q[strap_arb_pkg::OPT_LSB + 2*g];
					o1_oe_n_q[g] <= ~cfg_q[strap_arb_pkg::OPT_LSB + 2*g + 1];
					o0_q[g] <= opt0_val_i[g];
					o1_q[g] <= opt1_val_i[g];
					o0_rx_q[g] <= cfg_q[strap_arb_pkg::OPT_LSB + 2*g] ? 1'b0 : opt0_in_i[g];
					o1_rx_q[g] <= cfg_q[strap_arb_pkg::OPT_LSB + 2*g + 1] ? 1'b0 : opt1_in_i[g];
				end
			end
		end
	endgenerate

	// both fitted or both absent merge the two requests
	// strap bit 0 takes only the second socket, bit 1 only the first, else both
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_q <= 1'b0;
		end else begin
			case (cfg_q[strap_arb_pkg::DREQ_LSB +: 2])
				2'h1: dma_q <= dreq_i[1];
				2'h2: dma_q <= dreq_i[0];
				default: dma_q <= |dreq_i;
			endcase
		end
	end

	// ------------------------------------------------------------
	// arbiter
	// ------------------------------------------------------------
	strap_arb_pkg::arb_state_t st_q;
	logic [strap_arb_pkg::XF_COUNT_W-1:0] left_q;
	// job length lives here so the arbiter can load it
	// software writes it through the bus slave below
	logic [strap_arb_pkg::XF_COUNT_W-1:0] xfer_count_q;
	logic multi_q, go_q, done_q;
	logic cbrq_seen;
	logic yield;

	// both terms read live pins; the state register is what samples them
	// a tied-low request line looks as if someone always wants the bus
	assign cbrq_seen = cbrq_bus ? cbrq_in_i : 1'b1;
	// losing priority forces release except while a multi job is transferring; common request only when allowed
	assign yield = !bprn_i || (any_req && cbrq_seen);

	// arbiter sequence: idle, request, transfer, then park or give up the bus
	// busy_in only matters while asking; an owner never looks at it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= strap_arb_pkg::ARB_IDLE;
			left_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				strap_arb_pkg::ARB_IDLE: begin
					// count is loaded once per job, never on a re-arbitration
					if (go_q) begin
						st_q <= strap_arb_pkg::ARB_REQ;
						left_q <= xfer_count_q;
					end
				end
				strap_arb_pkg::ARB_REQ: begin
					// a re-arbitration resumes where the job stopped; reloading here
					// would restart the count and a per-access job would never end
					if (bprn_i && !busy_in_i) begin
						st_q <= strap_arb_pkg::ARB_XFER;
					end
				end
				strap_arb_pkg::ARB_XFER: begin
					// multi jobs ignore yield until done, which keeps lock meaningful
					// the count runs down once per access, so a job of N makes N+1 accesses
					// one access per cycle; count zero ends the job
					if (left_q == '0) begin
						done_q <= 1'b1;
						st_q <= yield ? strap_arb_pkg::ARB_IDLE : strap_arb_pkg::ARB_PARK;
					end else begin
						left_q <= left_q - 1'b1;
						if (yield && !multi_q) begin
							st_q <= strap_arb_pkg::ARB_REQ;
						end
					end
				end
				strap_arb_pkg::ARB_PARK: begin
					// a new job while parked skips arbitration entirely
					// parked owner keeps busy so no re-arbitration is needed
					if (go_q) begin
						st_q <= strap_arb_pkg::ARB_XFER;
						left_q <= xfer_count_q;
					end else if (yield) begin
						st_q <= strap_arb_pkg::ARB_IDLE;
					end
				end
				default: st_q <= strap_arb_pkg::ARB_IDLE;
			endcase
		end
	end

	// pin drive, registered
	// every pin is a flop so nothing glitches onto the shared lines
	strap_arb_pkg::arb_pins_t arb_q;
	logic own_next;
	// owning covers transferring and parked; busy follows one edge later
	assign own_next = (st_q == strap_arb_pkg::ARB_XFER) || (st_q == strap_arb_pkg::ARB_PARK);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arb_q <= '{busy_out: 1'b0, busy_oe_n: 1'b1, breq: 1'b0, bpro: 1'b0,
				cbrq_out: 1'b0, cbrq_oe_n: 1'b1, lock: 1'b0};
		end else begin
			arb_q.busy_out <= own_next;
			arb_q.busy_oe_n <= !own_next;
			arb_q.breq <= (st_q == strap_arb_pkg::ARB_REQ) || own_next;
			// priority passes down only when this master does not want the bus
			arb_q.bpro <= serial && bprn_i && (st_q == strap_arb_pkg::ARB_IDLE);
			arb_q.cbrq_out <= (st_q == strap_arb_pkg::ARB_REQ);
			arb_q.cbrq_oe_n <= !(cbrq_bus && (st_q == strap_arb_pkg::ARB_REQ));
			arb_q.lock <= lock_en && multi_q && (st_q == strap_arb_pkg::ARB_XFER);
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic [31:0] rdat_q;
	logic ack_q, done_sticky_q;
	logic req;
	// taken only while ack is low, so one cycle writes once
	assign req = wb_cyc_i && wb_stb_i && !ack_q;

	// count and control bits sit in separate byte lanes and may be written apart
	// control word; go self-clears once the arbiter takes the job
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			go_q <= 1'b0;
			multi_q <= 1'b0;
			irq_sw_q <= 1'b0;
			xfer_count_q <= '0;
		end else begin
			if (req && wb_we_i && wb_adr_i == strap_arb_pkg::XFER_CTRL_OFF && wb_sel_i[0]) begin
				go_q <= wb_dat_i[strap_arb_pkg::XF_GO_BIT];
				multi_q <= wb_dat_i[strap_arb_pkg::XF_MULTI_BIT];
				irq_sw_q <= wb_dat_i[strap_arb_pkg::XF_IRQ_BIT];
			end else if (st_q == strap_arb_pkg::ARB_REQ || st_q == strap_arb_pkg::ARB_PARK) begin
				go_q <= 1'b0;
			end
			if (req && wb_we_i && wb_adr_i == strap_arb_pkg::XFER_CTRL_OFF && wb_sel_i[1]) begin
				xfer_count_q <= wb_dat_i[strap_arb_pkg::XF_COUNT_LSB +: strap_arb_pkg::XF_COUNT_W];
			end
		end
	end

	// a clear racing a finishing job loses, so no completion is missed
	// done flag: set wins over a same-cycle write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_sticky_q <= 1'b0;
		end else if (done_q) begin
			done_sticky_q <= 1'b1;
		end else if (req && wb_we_i && wb_adr_i == strap_arb_pkg::STATUS_OFF && wb_sel_i[0] && wb_dat_i[0]) begin
			done_sticky_q <= 1'b0;
		end
	end

	// read data follows the live address each cycle; only the acked copy counts
	// single wait state, unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= strap_arb_pkg::WORD_ZERO;
		end else begin
			ack_q <= req;
			case (wb_adr_i)
				strap_arb_pkg::STRAP_CFG_OFF: rdat_q <= cfg_q;
				strap_arb_pkg::WAKE_ADDR_OFF: rdat_q <= {16'h0000, wake_q};
				strap_arb_pkg::XFER_CTRL_OFF: rdat_q <= {16'h0000, xfer_count_q, 5'h00, irq_sw_q, multi_q, go_q};
				// exactly 32 bits: option receive bits sit at 9:6 right above the state
				strap_arb_pkg::STATUS_OFF: rdat_q <= {22'h000000, o1_rx_q[1:0], o0_rx_q[1:0],
					st_q, arb_q.lock, arb_q.busy_out, done_sticky_q};
				strap_arb_pkg::PORT_NUM_OFF: rdat_q <= {16'h0000, port_num_q};
				strap_arb_pkg::PAGE_BASE_OFF: rdat_q <= {27'h0000000, bus16_q, page_q};
				default: rdat_q <= strap_arb_pkg::WORD_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// plain wires from the flops above; no logic between a flop and a pin
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign arb_o = arb_q;
	assign int_o = int_q;
	assign bus_16_o = bus16_q;
	assign page_o = page_q;
	assign term_en_o = term_q;
	assign opt0_out_o = o0_q;
	assign opt0_oe_n_o = o0_oe_n_q;
	assign opt1_out_o = o1_q;
	assign opt1_oe_n_o = o1_oe_n_q;
	assign dma_req_o = dma_q;

endmodule : strap_arb

// [test/strap_arb_monitor.sv]
// checker of the strap arbitration block ports
`timescale 1ns/1ps

module strap_arb_monitor #(
	parameter int SOCKETS = 2
) (
	// clock, reset and register bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// straps and bus side
	input wire logic [31:0] strap_cfg_i,
	input wire logic [strap_arb_pkg::WAKE_W-1:0] wake_strap_i,
	input wire logic irq_i,
	input wire logic bprn_i,
	input wire logic cbrq_in_i,
	input wire strap_arb_pkg::arb_pins_t arb_o,
	input wire logic [7:0] int_o,
	input wire logic bus_16_o,
	input wire logic [strap_arb_pkg::PAGE_W-1:0] page_o,
	// sockets
	input wire logic [SOCKETS-1:0] dreq_i,
	input wire logic [SOCKETS-1:0] opt0_val_i,
	input wire logic [SOCKETS-1:0] opt1_val_i,
	input wire logic [SOCKETS-1:0] opt0_out_o,
	input wire logic [SOCKETS-1:0] opt1_out_o,
	input wire logic [SOCKETS-1:0] term_en_o,
	input wire logic [SOCKETS-1:0] opt0_oe_n_o,
	input wire logic [SOCKETS-1:0] opt1_oe_n_o,
	input wire logic dma_req_o
);
	logic [1:0] up_q;
	logic ok;
	logic [31:0] s;
	logic dma_x;

	// strap-derived outputs are only valid two edges after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	// expected routing, one socket only or both
	assign ok = up_q == 2'h3;
	assign s = strap_cfg_i;
	assign dma_x = (s[21:20] == 2'h1) ? dreq_i[1] : (s[21:20] == 2'h2) ? dreq_i[0] : |dreq_i;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// sequences and assertions
	// ------------------------------------------------------------
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// owner with nobody entitled to take the bus
	sequence s_quiet_own;
		ok && arb_o.busy_out && bprn_i && s[2] && !(s[3] && cbrq_in_i);
	endsequence

	AST_ACK_ONE: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one pulse");
	AST_PORT_NUM: assert property (s_take ##0 (ok && !wb_we_i && wb_adr_i == strap_arb_pkg::PORT_NUM_OFF) |=>
		wb_dat_o == {16'h0000, wake_strap_i & (s[0] ? 16'hFFFF : 16'h00FF)})
		else $error("port number wrong");
	AST_SHAPE: assert property (ok |-> bus_16_o == s[1] &&
		page_o == (s[6] ? strap_arb_pkg::PAGE_HIGH : strap_arb_pkg::PAGE_LOW))
		else $error("data width or page wrong");
	AST_INT: assert property ((ok && irq_i) [*3] |-> int_o == 8'h01 << s[10:8])
		else $error("interrupt line wrong");
	AST_SOCK: assert property (ok |-> term_en_o == s[13:12] && opt0_oe_n_o == ~{s[18], s[16]} &&
		opt1_oe_n_o == ~{s[19], s[17]})
		else $error("socket direction wrong");
	AST_OPT_OUT: assert property (ok |=> opt0_out_o == $past(opt0_val_i) &&
		opt1_out_o == $past(opt1_val_i))
		else $error("option drive value wrong");
	AST_DMA: assert property (ok |=> dma_req_o == $past(dma_x))
		else $error("dma routing wrong");
	AST_PRIO_OFF: assert property (ok && !s[4] |-> !arb_o.bpro)
		else $error("priority out in parallel mode");
	AST_LOCK_OFF: assert property (ok && !s[5] |-> !arb_o.lock)
		else $error("lock while disabled");
	AST_BUSY_DRV: assert property (arb_o.busy_out |-> !arb_o.busy_oe_n)
		else $error("busy not driven");
	AST_HOLD: assert property (s_quiet_own [*3] |=> arb_o.busy_out)
		else $error("bus given up without cause");
	AST_YIELD: assert property (ok && arb_o.busy_out && !s[5] && (!bprn_i || (s[3] && (!s[2] || cbrq_in_i)))
		|-> ##[1:300] !arb_o.busy_out)
		else $error("bus not surrendered");
endmodule : strap_arb_monitor

bind strap_arb strap_arb_monitor #(.SOCKETS(SOCKETS)) mon (.*);

// [test/bus_masters_model.sv]
// behavioural model of the other masters on the shared bus
`timescale 1ns/1ps

module bus_masters_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench requests and the block's busy
	input wire logic hi_req_i,
	input wire logic lo_req_i,
	input wire logic dut_busy_i,
	// arbitration lines toward the block
	output logic bprn_o,
	output logic busy_o,
	output logic cbrq_o
);
	logic grant_q;

	// a requester takes the bus only after the block lets go
	always_ff @(posedge clk_i) begin
		if (rst_i || !(hi_req_i || lo_req_i)) begin
			grant_q <= 1'b0;
		end else if (!dut_busy_i) begin
			grant_q <= 1'b1;
		end
	end
	// higher request removes priority; common request drops once control is held
	assign bprn_o = !hi_req_i;
	assign cbrq_o = (hi_req_i || lo_req_i) && !grant_q;
	assign busy_o = grant_q;
endmodule : bus_masters_model

// [test/tb.sv]
// self-checking bench for the strap arbitration block
`timescale 1ns/1ps

module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	logic [31:0] rd_q;
	logic ack;
	logic [31:0] strap = 32'h0;
	logic [15:0] wake = 16'h0;
	logic irq = 1'b0;
	logic hi = 1'b0;
	logic lo = 1'b0;
	logic [7:0] sock = 8'h00;
	logic [1:0] dreq = 2'h0;
	logic bprn, busy_in, cbrq, b16, dma;
	logic [3:0] page;
	logic [7:0] ints;
	strap_arb_pkg::arb_pins_t arb;
	int checks = 0;
	int bad_count = 0;

	// 250 MHz
	always #2 clk_i = ~clk_i;

	strap_arb dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .strap_cfg_i(strap), .wake_strap_i(wake),
		.irq_i(irq), .bprn_i(bprn), .busy_in_i(busy_in), .cbrq_in_i(cbrq), .arb_o(arb), .int_o(ints),
		.bus_16_o(b16), .page_o(page), .opt0_in_i(sock[1:0]), .opt1_in_i(sock[3:2]), .dreq_i(dreq),
		.opt0_val_i(sock[5:4]), .opt1_val_i(sock[7:6]), .term_en_o(), .opt0_out_o(), .opt0_oe_n_o(),
		.opt1_out_o(), .opt1_oe_n_o(), .dma_req_o(dma));
	bus_masters_model peer (.clk_i(clk_i), .rst_i(rst_i), .hi_req_i(hi), .lo_req_i(lo),
		.dut_busy_i(arb.busy_out), .bprn_o(bprn), .busy_o(busy_in), .cbrq_o(cbrq));

	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop();
		chk("wait", 32'h0, 32'h1);
		results();
	endtask : stop

	// one classic cycle, released at the edge where ack is sampled
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) stop();
		rd_q = rd;
		cyc <= 1'b0;
	endtask : rw

	// straps only change under reset
	task automatic cfg(input logic [31:0] s);
		@(posedge clk_i);
		rst_i <= 1'b1;
		strap <= s;
		wake <= 16'($urandom);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : cfg

	task automatic wait_busy();
		int n;
		n = 0;
		while (arb.busy_out !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) stop();
	endtask : wait_busy

	// job, park, then a lower and a higher requester
	task automatic job(input logic [31:0] s, input logic [15:0] ctl, input logic l, input logic hold);
		cfg(s);
		chk("prio", 32'(arb.bpro), 32'(s[4]));
		rw(1'b1, strap_arb_pkg::XFER_CTRL_OFF, {16'h0, ctl});
		wait_busy();
		repeat (2) @(posedge clk_i);
		chk("lock", 32'(arb.lock), 32'(s[5] & ctl[1]));
		repeat (30) @(posedge clk_i);
		chk("park", 32'(arb.busy_out), 32'(s[2]));
		lo <= l;
		repeat (30) @(posedge clk_i);
		chk("yield lo", 32'(arb.busy_out), 32'(hold));
		hi <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk("yield hi", 32'(arb.busy_out), 32'h0);
		rw(1'b0, strap_arb_pkg::STATUS_OFF, 32'h0);
		chk("done", 32'(rd_q[0]), 32'h1);
		rw(1'b1, strap_arb_pkg::STATUS_OFF, 32'h1);
		rw(1'b0, strap_arb_pkg::STATUS_OFF, 32'h0);
		chk("done clear", 32'(rd_q[0]), 32'h0);
		lo <= 1'b0;
		hi <= 1'b0;
	endtask : job

	function automatic logic exp_dma(input logic [1:0] m, input logic [1:0] r);
		return (m == 2'h1) ? r[1] : (m == 2'h2) ? r[0] : |r;
	endfunction : exp_dma

	// random straps with all-absent and all-fitted corners
	initial begin
		logic [31:0] s;
		void'($urandom(32'h444DD2E8));
		for (int i = 0; i < 8; i++) begin
			s = (i == 0) ? 32'h0 : (i == 7) ? 32'h003F3073 : $urandom & 32'h003F3073;
			s[10:8] = 3'(i);
			cfg(s);
			sock <= 8'($urandom);
			chk("bus16", 32'(b16), 32'(s[1]));
			chk("page", 32'(page), s[6] ? 32'hF : 32'h0);
			rw(1'b0, strap_arb_pkg::PORT_NUM_OFF, 32'h0);
			chk("port", rd_q, {16'h0, s[0] ? wake : {8'h00, wake[7:0]}});
			rw(1'b1, strap_arb_pkg::STRAP_CFG_OFF, ~s);
			rw(1'b0, strap_arb_pkg::STRAP_CFG_OFF, 32'h0);
			chk("strap", rd_q, s);
			rw(1'b0, 8'hFC, 32'h0);
			chk("unmapped", rd_q, 32'h0);
			rw(1'b0, strap_arb_pkg::STATUS_OFF, 32'h0);
			chk("opt rx", 32'(rd_q[9:6]), 32'(sock[3:0] & ~{s[19], s[17], s[18], s[16]}));
			irq <= 1'b1;
			repeat (4) @(posedge clk_i);
			chk("int", 32'(ints), 32'(8'h01 << i));
			irq <= 1'b0;
			rw(1'b1, strap_arb_pkg::XFER_CTRL_OFF, 32'h4);
			repeat (2) @(posedge clk_i);
			chk("soft int", 32'(ints), 32'(8'h01 << i));
			rw(1'b1, strap_arb_pkg::XFER_CTRL_OFF, 32'h0);
			repeat (2) @(posedge clk_i);
			chk("int off", 32'(ints), 32'h0);
			for (int k = 0; k < 4; k++) begin
				dreq <= 2'(k);
				repeat (3) @(posedge clk_i);
				chk("dma", 32'(dma), 32'(exp_dma(s[21:20], 2'(k))));
			end
		end
		job(32'h04, 16'h0401, 1'b1, 1'b1);
		job(32'h0C, 16'h0401, 1'b1, 1'b0);
		job(32'h08, 16'h0401, 1'b0, 1'b0);
		job(32'h34, 16'h0803, 1'b1, 1'b1);
		job(32'h14, 16'h0001, 1'b0, 1'b1);
		results();
	end
endmodule : tb
